//--- hdl/irq_agg_pkg.sv
// Constants, field layouts and carriers of the interrupt aggregator.
// Assumes a 50 MHz core clock and a host reading flags over the serial link.
package irq_agg_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MIN_PULSE_NS = 10000;
  localparam int unsigned IRQ_TIMEOUT_US = 6000;
  // Least time rounds up, longest time rounds down
  localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IRQ_TIMEOUT_CYC = (IRQ_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 19;

  // ==========================================================
  // Register addresses and read-only command code
  // ==========================================================
  localparam logic [2:0] REG_WAKE = 3'h0;
  localparam logic [2:0] REG_STATE = 3'h1;
  localparam logic [2:0] REG_FAIL = 3'h2;
  localparam logic [2:0] CMD_READ_ONLY = 3'h7;

  // ==========================================================
  // Source positions in the flag vector
  // ==========================================================
  localparam int unsigned NSRC = 15;
  localparam int unsigned SRC_HEAT_WARN = 0;
  localparam int unsigned SRC_S2_OT = 1;
  localparam int unsigned SRC_XCVR_OT = 2;
  localparam int unsigned SRC_CAN_FAIL = 3;
  localparam int unsigned SRC_LIN_FAIL = 4;
  localparam int unsigned SRC_S2_UV = 5;
  localparam int unsigned SRC_S3_UV = 6;
  localparam int unsigned SRC_S3_OC = 7;
  localparam int unsigned SRC_SPI_FAIL = 8;
  localparam int unsigned SRC_RESET = 9;
  localparam int unsigned SRC_BAD_WDOG = 10;
  localparam int unsigned SRC_BUS_WAKE = 11;
  localparam int unsigned SRC_LIN_WAKE = 12;
  localparam int unsigned SRC_PIN_WAKE = 13;
  localparam int unsigned SRC_CYC_WAKE = 14;
  // Bits 0..7 are event/state flags, 8..14 event-only flags
  localparam logic [NSRC-1:0] STATE_KIND = 15'h00FF;
  localparam logic [NSRC-1:0] MASK_RESET = 15'h7FFF;
  localparam logic [NSRC-1:0] WAKE_BITS = 15'h7800;
  localparam logic [NSRC-1:0] STATE_BITS = 15'h00FF;
  localparam logic [NSRC-1:0] FAIL_BITS = 15'h0700;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic valid;
    logic [2:0] cmd;
    logic [2:0] addr;
  } spi_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } spi_rsp_s;

  typedef enum logic [2:0] {
    LINE_IDLE = 3'b001,
    LINE_LOW = 3'b010,
    LINE_GAP = 3'b100
  } line_state_e;

endpackage : irq_agg_pkg

//--- hdl/sbc_interrupt_aggregator.sv
// Interrupt aggregator: per-source flags, masking and the interrupt line.
// Assumes condition and event inputs come from logic on the same clock;
// only the interrupt pin itself is asynchronous.
`timescale 1ns/100ps

module sbc_interrupt_aggregator
  import irq_agg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = IRQ_TIMEOUT_CYC,
  parameter bit SW_DEV_VARIANT = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  // Condition levels
  input wire logic heat_warn_cond,
  input wire logic supply2_overheat_cond,
  input wire logic bus_xcvr_overheat_cond,
  input wire logic can_fail_cond,
  input wire logic lin_fail_cond,
  input wire logic supply2_undervolt_cond,
  input wire logic supply3_undervolt_cond,
  input wire logic supply3_overcur_cond,
  input wire logic supply2_switching_off,
  input wire logic supply3_switching_off,
  input wire logic supply3_inhibit,
  input wire logic supply2_switch_on,
  input wire logic supply3_switch_on,
  // Event levels, taken on their rising edge
  input wire logic spi_fail_evt,
  input wire logic reset_evt,
  input wire logic bad_wdog_evt,
  input wire logic bus_wake_evt,
  input wire logic lin_wake_evt,
  input wire logic pin_wake_evt,
  input wire logic cyclic_wake_evt,
  // Mode and mask control
  input wire logic irq_mode_active,
  input wire logic restart_pulse,
  input wire logic mask_wr,
  input wire logic [NSRC-1:0] mask_wdata,
  output logic [NSRC-1:0] mask_q,
  // Serial register access
  input wire spi_req_s spi_req,
  output spi_rsp_s spi_rsp_q,
  // Interrupt pin and configuration strap
  input wire logic reset_out_n,
  input wire logic int_pin_in,
  output logic int_pin_out,
  output logic int_pin_oe,
  output logic config_alt_q,
  output logic [NSRC-1:0] flags
);

  // ==========================================================
  // Pin synchroniser and configuration strap
  // ==========================================================
  logic pin_meta_q;
  logic pin_sync_q;
  logic [1:0] sync_fill_q;
  logic strap_done_q;

  // Two flops before the strap level is used
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= int_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Strap caught once with the reset output high, but only after the
  // synchroniser has refilled, so its reset level is never taken as the pin
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_fill_q <= 2'h0;
      strap_done_q <= 1'b0;
      config_alt_q <= 1'b0;
    end else begin
      sync_fill_q <= {sync_fill_q[0], 1'b1};
      if (reset_out_n && sync_fill_q[1] && !strap_done_q) begin
        config_alt_q <= pin_sync_q;
        strap_done_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Source levels and triggers
  // ==========================================================
  logic [NSRC-1:0] lvl;
  logic [NSRC-1:0] lvl_prev_q;
  logic [NSRC-1:0] rise;
  logic [NSRC-1:0] fall;
  logic [NSRC-1:0] trig;
  logic [NSRC-1:0] cond;
  logic s2_on_prev_q;
  logic s3_on_prev_q;

  always_comb begin
    lvl = '0;
    lvl[SRC_HEAT_WARN] = heat_warn_cond;
    lvl[SRC_S2_OT] = supply2_overheat_cond;
    lvl[SRC_XCVR_OT] = bus_xcvr_overheat_cond;
    lvl[SRC_CAN_FAIL] = can_fail_cond;
    lvl[SRC_LIN_FAIL] = lin_fail_cond;
    lvl[SRC_S2_UV] = supply2_undervolt_cond;
    lvl[SRC_S3_UV] = supply3_undervolt_cond;
    lvl[SRC_S3_OC] = supply3_overcur_cond;
    lvl[SRC_SPI_FAIL] = spi_fail_evt;
    lvl[SRC_RESET] = reset_evt & SW_DEV_VARIANT;
    lvl[SRC_BAD_WDOG] = bad_wdog_evt;
    lvl[SRC_BUS_WAKE] = bus_wake_evt;
    lvl[SRC_LIN_WAKE] = lin_wake_evt;
    lvl[SRC_PIN_WAKE] = pin_wake_evt;
    lvl[SRC_CYC_WAKE] = cyclic_wake_evt;
  end

  // Previous levels for edge detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lvl_prev_q <= '0;
      s2_on_prev_q <= 1'b0;
      s3_on_prev_q <= 1'b0;
    end else begin
      lvl_prev_q <= lvl;
      s2_on_prev_q <= supply2_switch_on;
      s3_on_prev_q <= supply3_switch_on;
    end
  end

  // Edges of every source level
  assign rise = lvl & ~lvl_prev_q;
  assign fall = ~lvl & lvl_prev_q;
  // Only event/state sources keep showing their present condition
  assign cond = lvl & STATE_KIND;

  // Trigger per source by its activation kind
  always_comb begin
    trig = rise;
    trig[SRC_S2_UV] = ((rise[SRC_S2_UV] | fall[SRC_S2_UV])
                       & ~supply2_switching_off)
                      | (supply2_switch_on & ~s2_on_prev_q);
    trig[SRC_S3_UV] = ((rise[SRC_S3_UV] | fall[SRC_S3_UV])
                       & ~supply3_switching_off)
                      | (supply3_switch_on & ~s3_on_prev_q);
    trig[SRC_S3_OC] = rise[SRC_S3_OC] & ~supply3_inhibit;
  end

  // ==========================================================
  // Read-only access decode
  // ==========================================================
  logic ro_access;
  logic [NSRC-1:0] clr_sel;
  logic summary;

  // Only the read-only command clears anything
  assign ro_access = spi_req.valid && (spi_req.cmd == CMD_READ_ONLY);

  // Flags that each read-only access clears
  always_comb begin
    clr_sel = '0;
    if (ro_access) begin
      unique case (spi_req.addr)
        REG_WAKE: clr_sel = WAKE_BITS;
        REG_STATE: clr_sel = STATE_BITS;
        REG_FAIL: clr_sel = FAIL_BITS;
        default: clr_sel = '0;
      endcase
    end
  end

  // ==========================================================
  // Per-source flag latches
  // ==========================================================
  // Latched part of each flag
  logic [NSRC-1:0] latch_q;

  generate
    for (genvar i = 0; i < NSRC; i++) begin : g_flag
      // Set wins over a read clear in the same cycle; mask not used here
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          latch_q[i] <= 1'b0;
        end else if (trig[i]) begin
          latch_q[i] <= 1'b1;
        end else if (clr_sel[i]) begin
          latch_q[i] <= 1'b0;
        end
      end
      // Event/state flag shows latch, then the live condition
      assign flags[i] = latch_q[i] | cond[i];
    end
  endgenerate

  // Summary covers every non-wake flag
  assign summary = |(flags & (STATE_BITS | FAIL_BITS));

  // ==========================================================
  // Read data returned to the serial interface
  // ==========================================================
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      spi_rsp_q <= '0;
    end else begin
      spi_rsp_q.valid <= spi_req.valid;
      if (spi_req.valid) begin
        unique case (spi_req.addr)
          REG_WAKE: spi_rsp_q.data <= {3'h0, flags[SRC_CYC_WAKE:SRC_BUS_WAKE], summary};
          REG_STATE: spi_rsp_q.data <= flags[SRC_S3_OC:SRC_HEAT_WARN];
          REG_FAIL: spi_rsp_q.data <= {5'h00, flags[SRC_BAD_WDOG:SRC_SPI_FAIL]};
          default: spi_rsp_q.data <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // Mask register
  // ==========================================================
  // Mask: restart re-enables every source
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= MASK_RESET;
    end else if (restart_pulse) begin
      mask_q <= MASK_RESET;
    end else if (mask_wr) begin
      mask_q <= mask_wdata;
    end
  end

  // ==========================================================
  // Interrupt line sequencer
  // ==========================================================
  line_state_e line_q;
  logic [CNT_W-1:0] cnt_q;
  logic pending_q;
  logic release_req_q;
  logic new_irq;
  logic read_000;
  logic min_done;
  logic timeout_hit;

  // Pulse start, release and timeout decode
  assign new_irq = |(trig & mask_q) && irq_mode_active;
  assign read_000 = ro_access && (spi_req.addr == REG_WAKE);
  assign min_done = cnt_q >= CNT_W'(MIN_PULSE_CYC - 1);
  assign timeout_hit = cnt_q >= CNT_W'(TIMEOUT_CYC - 1);

  // Counter from pulse start, running through the low phase and the gap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (!irq_mode_active || line_q == LINE_IDLE) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Line state: idle, pulled low, then the enforced gap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_q <= LINE_IDLE;
    end else if (!irq_mode_active) begin
      line_q <= LINE_IDLE;
    end else begin
      unique case (line_q)
        LINE_IDLE: begin
          if (new_irq || pending_q) begin
            line_q <= LINE_LOW;
          end
        end
        LINE_LOW: begin
          if ((read_000 || release_req_q) && min_done) begin
            line_q <= LINE_GAP;
          end else if (timeout_hit) begin
            line_q <= LINE_GAP;
          end
        end
        LINE_GAP: begin
          if (timeout_hit) begin
            line_q <= LINE_IDLE;
          end
        end
      endcase
    end
  end

  // An early read is remembered until the minimum pulse has passed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      release_req_q <= 1'b0;
    end else if (!irq_mode_active || line_q != LINE_LOW) begin
      release_req_q <= 1'b0;
    end else if (read_000) begin
      release_req_q <= 1'b1;
    end
  end

  // Sources before the read share the pulse; later ones wait for the gap end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pending_q <= 1'b0;
    end else if (!irq_mode_active) begin
      pending_q <= 1'b0;
    end else if (line_q == LINE_IDLE) begin
      pending_q <= 1'b0;
    end else if (new_irq && (line_q == LINE_GAP || read_000 || release_req_q)) begin
      pending_q <= 1'b1;
    end
  end

  // Open-drain pin: drive low while the pulse runs, never during init
  // Never driven high; the outside pull-up gives the released level
  assign int_pin_out = 1'b0;
  assign int_pin_oe = (line_q == LINE_LOW) && reset_out_n;

endmodule : sbc_interrupt_aggregator

//--- sim/irq_agg_chk.sv
// Port checker for the interrupt aggregator, bound to its top module.
// Assumes TIMEOUT_CYC is set above the minimum pulse count.
`timescale 1ns/100ps
module irq_agg_chk
  import irq_agg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = IRQ_TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic irq_mode_active,
  input wire logic restart_pulse,
  input wire logic mask_wr,
  input wire logic [NSRC-1:0] mask_wdata,
  input wire logic [NSRC-1:0] mask_q,
  input wire spi_req_s spi_req,
  input wire spi_rsp_s spi_rsp_q,
  input wire logic reset_out_n,
  input wire logic int_pin_oe,
  input wire logic config_alt_q
);
  logic [18:0] low_q;
  logic [18:0] since_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================
  // Helper counters
  // ==========================================
  // Cycles the line has been held low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) low_q <= '0;
    else low_q <= int_pin_oe ? low_q + 19'h1 : '0;
  end
  // Cycles since the last activation, saturating
  always_ff @(posedge clock or posedge rst) begin
    if (rst) since_q <= 19'h7FFFF;
    else if (int_pin_oe && low_q == '0) since_q <= 19'h1;
    else if (since_q != 19'h7FFFF) since_q <= since_q + 19'h1;
  end
  // ==========================================
  // Assertions
  // ==========================================
  a_mask_restart: assert property (restart_pulse && !mask_wr |=> mask_q == 15'h7FFF)
    else $error("mask not all ones after restart");
  a_mask_write: assert property (mask_wr && !restart_pulse |=> mask_q == $past(mask_wdata))
    else $error("mask write not taken");
  a_rsp_answer: assert property (spi_req.valid |=> spi_rsp_q.valid)
    else $error("access got no answer");
  a_rsp_single: assert property (!spi_req.valid |=> !spi_rsp_q.valid)
    else $error("answer without access");
  a_mode_idle: assert property (!irq_mode_active |=> !int_pin_oe)
    else $error("line driven outside active modes");
  a_pulse_min: assert property ($fell(int_pin_oe) && $past(irq_mode_active)
    |-> low_q >= MIN_PULSE_CYC)
    else $error("line pulse too short");
  a_pulse_max: assert property (int_pin_oe |-> low_q < TIMEOUT_CYC)
    else $error("line pulse beyond timeout");
  a_act_gap: assert property ($rose(int_pin_oe) |-> since_q >= TIMEOUT_CYC)
    else $error("activations too close");
  a_strap_hold: assert property (reset_out_n && $past(reset_out_n, 4) |-> $stable(config_alt_q))
    else $error("strap changed after sampling");
endmodule : irq_agg_chk

bind sbc_interrupt_aggregator irq_agg_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (
  .clock(clock), .rst(rst), .irq_mode_active(irq_mode_active), .restart_pulse(restart_pulse),
  .mask_wr(mask_wr), .mask_wdata(mask_wdata), .mask_q(mask_q), .spi_req(spi_req),
  .spi_rsp_q(spi_rsp_q), .reset_out_n(reset_out_n), .int_pin_oe(int_pin_oe),
  .config_alt_q(config_alt_q)
);

//--- sim/irq_host_model.sv
// Host model: issues read-only accesses and collects the answers.
// Assumes the bench raises go for one cycle per access.
`timescale 1ns/100ps
module irq_host_model
  import irq_agg_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [2:0] addr,
  input wire spi_rsp_s spi_rsp_q,
  output spi_req_s spi_req,
  output logic [7:0] rd_data,
  output logic done
);
  // One-cycle request; idle fields flip so stale values never look valid
  always_ff @(posedge clock or posedge rst) begin
    if (rst) spi_req <= '0;
    else if (go) spi_req <= '{1'b1, CMD_READ_ONLY, addr};
    else spi_req <= '{1'b0, ~spi_req.cmd, ~spi_req.addr};
  end
  // Take the answer in the cycle it stands
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= spi_rsp_q.valid;
      rd_data <= spi_rsp_q.valid ? spi_rsp_q.data : rd_data;
    end
  end
endmodule : irq_host_model

//--- sim/tb_top.sv
// Testbench for the interrupt aggregator: strap, flags, reads and line timing.
// Assumes the checker and host model are compiled first.
`timescale 1ns/100ps
module tb_top
  import irq_agg_pkg::*;
;
  localparam int unsigned TO = 1000;
  logic clock, rst, mode, restart, mwr, sw2, sw3, inh, on2, on3, rout_n, pin_in, go, done;
  logic oe, pout, cfg;
  logic [7:0] cnd;
  logic [6:0] evt;
  logic [NSRC-1:0] mdata, mask_q, flags;
  logic [NSRC-1:0] dev_flags;
  logic [2:0] addr;
  logic [7:0] rd_data;
  spi_req_s req;
  spi_rsp_s rsp;
  int fails = 0;
  int num_checks = 0;
  // ==========================================
  // Design, host and clock
  // ==========================================
  sbc_interrupt_aggregator #(.TIMEOUT_CYC(TO)) i_dut (
    .clock(clock), .rst(rst), .heat_warn_cond(cnd[0]), .supply2_overheat_cond(cnd[1]),
    .bus_xcvr_overheat_cond(cnd[2]), .can_fail_cond(cnd[3]), .lin_fail_cond(cnd[4]),
    .supply2_undervolt_cond(cnd[5]), .supply3_undervolt_cond(cnd[6]),
    .supply3_overcur_cond(cnd[7]), .supply2_switching_off(sw2), .supply3_switching_off(sw3),
    .supply3_inhibit(inh), .supply2_switch_on(on2), .supply3_switch_on(on3),
    .spi_fail_evt(evt[0]), .reset_evt(evt[1]), .bad_wdog_evt(evt[2]), .bus_wake_evt(evt[3]),
    .lin_wake_evt(evt[4]), .pin_wake_evt(evt[5]), .cyclic_wake_evt(evt[6]),
    .irq_mode_active(mode), .restart_pulse(restart), .mask_wr(mwr), .mask_wdata(mdata),
    .mask_q(mask_q), .spi_req(req), .spi_rsp_q(rsp), .reset_out_n(rout_n),
    .int_pin_in(oe ? 1'b0 : pin_in), .int_pin_out(pout), .int_pin_oe(oe),
    .config_alt_q(cfg), .flags(flags)
  );
  irq_host_model i_host (
    .clock(clock), .rst(rst), .go(go), .addr(addr), .spi_rsp_q(rsp), .spi_req(req),
    .rd_data(rd_data), .done(done)
  );
  // Development variant on the same stimulus; only its flags are compared
  sbc_interrupt_aggregator #(.TIMEOUT_CYC(TO), .SW_DEV_VARIANT(1'b1)) i_dut_dev (
    .clock(clock), .rst(rst), .heat_warn_cond(cnd[0]), .supply2_overheat_cond(cnd[1]),
    .bus_xcvr_overheat_cond(cnd[2]), .can_fail_cond(cnd[3]), .lin_fail_cond(cnd[4]),
    .supply2_undervolt_cond(cnd[5]), .supply3_undervolt_cond(cnd[6]),
    .supply3_overcur_cond(cnd[7]), .supply2_switching_off(sw2), .supply3_switching_off(sw3),
    .supply3_inhibit(inh), .supply2_switch_on(on2), .supply3_switch_on(on3),
    .spi_fail_evt(evt[0]), .reset_evt(evt[1]), .bad_wdog_evt(evt[2]), .bus_wake_evt(evt[3]),
    .lin_wake_evt(evt[4]), .pin_wake_evt(evt[5]), .cyclic_wake_evt(evt[6]),
    .irq_mode_active(mode), .restart_pulse(restart), .mask_wr(mwr), .mask_wdata(mdata),
    .mask_q(), .spi_req(req), .spi_rsp_q(), .reset_out_n(rout_n),
    .int_pin_in(pin_in), .int_pin_out(), .int_pin_oe(),
    .config_alt_q(), .flags(dev_flags)
  );
  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ==========================================
  // Tasks
  // ==========================================
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_oe(input logic v, input int n);
    int k;
    k = 0;
    while (oe !== v && k < n) begin
      tick();
      k++;
    end
    chk(16'(oe), 16'(v));
  endtask : wait_oe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    int k;
    go = 1'b1;
    addr = a;
    tick();
    go = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 8) begin
      tick();
      k++;
    end
    chk(16'({done, rd_data}), 16'({1'b1, exp}));
  endtask : rd
  task automatic end_sim();
    $display("num_checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    {rst, mode} = 2'b11;
    {restart, mwr, sw2, sw3, inh, on2, on3, rout_n, go} = 9'h000;
    {cnd, evt, addr, mdata} = '0;
    pin_in = 1'b1;
    repeat (10) tick();
    rst = 1'b0;
    chk(16'(mask_q), 16'h7FFF);
    rout_n = 1'b1;
    repeat (6) tick();
    chk(16'(cfg), 16'h0001);
    pin_in = 1'b0;
    repeat (6) tick();
    chk(16'(cfg), 16'h0001);
    pin_in = 1'b1;
    // All sources masked: flags still latch, line stays idle
    mwr = 1'b1;
    tick();
    mwr = 1'b0;
    for (int i = 0; i < 8; i++) begin
      cnd[i] = 1'b1;
      repeat (2) tick();
      cnd[i] = 1'b0;
      tick();
      chk(16'(flags[i]), 16'h0001);
    end
    for (int i = 0; i < 7; i++) begin
      evt[i] = 1'b1;
      tick();
      evt[i] = 1'b0;
      repeat (2) tick();
      chk(16'(flags[8+i]), (i == 1) ? 16'h0000 : 16'h0001);
    end
    chk(16'(dev_flags[9]), 16'h0001);
    chk(16'(oe), 16'h0000);
    rd(3'h0, 8'h1F);
    rd(3'h1, 8'hFF);
    rd(3'h2, 8'h05);
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h00);
    rd(3'h3, 8'h00);
    sw3 = 1'b1;
    cnd[6] = 1'b1;
    repeat (2) tick();
    cnd[6] = 1'b0;
    repeat (2) tick();
    sw3 = 1'b0;
    chk(16'(flags[6]), 16'h0000);
    inh = 1'b1;
    cnd[7] = 1'b1;
    repeat (2) tick();
    cnd[7] = 1'b0;
    repeat (2) tick();
    inh = 1'b0;
    chk(16'(flags[7]), 16'h0000);
    on2 = 1'b1;
    repeat (2) tick();
    on2 = 1'b0;
    rd(3'h1, 8'h20);
    restart = 1'b1;
    tick();
    restart = 1'b0;
    // Early read is held until the minimum pulse has passed
    evt[3] = 1'b1;
    tick();
    evt[3] = 1'b0;
    wait_oe(1'b1, 3);
    chk(16'(pout), 16'h0000);
    rd(3'h0, 8'h02);
    chk(16'(oe), 16'h0001);
    wait_oe(1'b0, 600);
    repeat (20) tick();
    evt[4] = 1'b1;
    tick();
    evt[4] = 1'b0;
    repeat (20) tick();
    chk(16'(oe), 16'h0000);
    wait_oe(1'b1, TO + 100);
    wait_oe(1'b0, TO + 100);
    rd(3'h0, 8'h04);
    repeat (TO + 10) tick();
    // Undervoltage raises the line on both edges
    cnd[5] = 1'b1;
    wait_oe(1'b1, 3);
    rd(3'h1, 8'h20);
    rd(3'h0, 8'h01);
    wait_oe(1'b0, 600);
    repeat (20) tick();
    cnd[5] = 1'b0;
    wait_oe(1'b1, TO + 100);
    rd(3'h1, 8'h20);
    rd(3'h0, 8'h00);
    wait_oe(1'b0, 600);
    repeat (TO + 10) tick();
    mode = 1'b0;
    evt[5] = 1'b1;
    tick();
    evt[5] = 1'b0;
    repeat (20) tick();
    chk(16'(oe), 16'h0000);
    mode = 1'b1;
    repeat (20) tick();
    chk(16'(oe), 16'h0000);
    end_sim();
  end
endmodule : tb_top
